/* File: verilog/ebu_block_memory.v */
/*
  ebu_block_memory: 9216-bit block memory with single, true dual,
  pseudo dual and fifo modes, one clock for all ports.
  assumes configuration inputs are static while in use and that
  user logic drives every request on clk.
*/
`timescale 1ns/1ps
`include "ebu_map.vh"
module ebu_block_memory (
  input  wire        clk,                  // clock
  input  wire        reset_n,              // global clear, async
  input  wire [1:0]  mode,                 // memory mode
  input  wire        rom_mode,             // write controls off
  input  wire [2:0]  a_width,              // port a width code
  input  wire [2:0]  b_width,              // port b width code
  input  wire [1:0]  a_wr_mode,            // port a write mode
  input  wire [1:0]  b_wr_mode,            // port b write mode
  input  wire        a_out_reg,            // port a output reg on
  input  wire        b_out_reg,            // port b output reg on
  input  wire        pl_en,                // preload strobe
  input  wire [8:0]  pl_addr,              // preload x18 index
  input  wire [17:0] pl_word,              // preload word
  input  wire        a_clk_en,             // port a enable
  input  wire        a_sel,                // port a select
  input  wire        a_wr_en,              // port a write
  input  wire [1:0]  a_byte_lane_select,   // port a lanes
  input  wire [12:0] a_addr,               // port a address
  input  wire [17:0] a_write_word_in,      // port a data
  input  wire        a_output_register_enable, // port a oce
  input  wire        port_a_latch_clear,   // port a clear
  output reg  [17:0] a_read_word,          // port a data out
  input  wire        b_clk_en,             // port b enable
  input  wire        b_sel,                // port b select
  input  wire        b_wr_en,              // port b write
  input  wire [1:0]  b_byte_lane_select,   // port b lanes
  input  wire [12:0] b_addr,               // port b address
  input  wire [17:0] b_write_word_in,      // port b data
  input  wire        b_output_register_enable, // port b oce
  input  wire        port_b_latch_clear,   // port b clear
  output reg  [17:0] b_read_word,          // port b / fifo out
  input  wire        fifo_reset,           // fifo global reset
  input  wire        read_pointer_rewind,  // read ptr to start
  input  wire        fifo_wr_en,           // fifo write
  input  wire [17:0] fifo_write_word_in,   // fifo data
  output wire        fifo_wr_ready,        // stage has room
  input  wire        write_port_select,    // write side select
  input  wire        full_chain_input,     // write side select 2
  input  wire        fifo_rd_en,           // fifo read
  input  wire        read_port_select,     // read side select
  input  wire        empty_chain_input,    // read side select 2
  input  wire        output_read_enable,   // read output enable
  input  wire [13:0] full_level,           // full threshold
  input  wire [13:0] afull_level,          // nearly full thr
  input  wire [13:0] aempty_level,         // nearly empty thr
  output reg         full_flag,            // fifo full
  output reg         nearly_full_flag,     // fifo nearly full
  output reg         nearly_empty_flag,    // fifo nearly empty
  output reg         empty_flag            // fifo empty
);
  function [4:0] fn_w;
    input [2:0] c;
    input       wide;
    begin
      case (c)
        `EBU_W1:  fn_w = 5'h01;
        `EBU_W2:  fn_w = 5'h02;
        `EBU_W4:  fn_w = 5'h04;
        `EBU_W18: fn_w = wide ? 5'h12 : 5'h09;
        default:  fn_w = 5'h09;
      endcase
    end
  endfunction

  function [13:0] fn_dm;
    input [2:0] c;
    input       wide;
    begin
      case (c)
        `EBU_W1:  fn_dm = 14'h1fff;
        `EBU_W2:  fn_dm = 14'h0fff;
        `EBU_W4:  fn_dm = 14'h07ff;
        `EBU_W18: fn_dm = wide ? 14'h01ff : 14'h03ff;
        default:  fn_dm = 14'h03ff;
      endcase
    end
  endfunction

  function [13:0] fn_base;
    input [13:0] ad;
    input [2:0]  c;
    input        wide;
    reg   [18:0] p;
    begin
      p = (ad & fn_dm(c, wide)) * fn_w(c, wide);
      fn_base = p[13:0];
    end
  endfunction

  function [17:0] fn_mask;
    input [4:0] w;
    reg   [18:0] m;
    begin
      m = (19'h1 << w) - 19'h1;
      fn_mask = m[17:0];
    end
  endfunction

  reg          mem [0:`EBU_BITS-1];
  reg          a_ce_q;
  reg          a_cs_q;
  reg          a_we_q;
  reg          b_ce_q;
  reg          b_cs_q;
  reg          b_we_q;
  reg  [1:0]   a_be_q, b_be_q;
  reg  [12:0]  a_ad_q, b_ad_q;
  reg  [17:0]  a_di_q, b_di_q;
  reg  [17:0]  la_q;
  reg  [17:0]  lb_q;
  reg  [17:0]  la_d;
  reg  [17:0]  lb_d;
  reg  [17:0]  rd_a;
  reg  [17:0]  rd_b;
  reg  [13:0]  wp_q;
  reg  [13:0]  rp_q;
  reg  [13:0]  wp_d;
  reg  [13:0]  rp_d;
  reg  [13:0]  cnt_d;
  integer      i, j;
  integer      n;
  wire         fifo_m = (mode == `EBU_MODE_FIFO);
  wire         wide = fifo_m | (mode == `EBU_MODE_PDP);
  wire [2:0]   bc = fifo_m ? a_width : b_width;
  wire [4:0]   wa = fn_w(a_width, wide);
  wire [4:0]   wb = fn_w(bc, wide);
  wire [14:0]  wrap_w = {fn_dm(a_width, wide), 1'b1};
  wire [13:0]  wrap = wrap_w[13:0];
  wire         st_valid;
  wire [17:0]  st_data;
  wire         pop, frd, a_rd, a_wr, b_rd, b_wr;
  wire [13:0]  ba, bb, pl_base;
  wire [17:0]  wda;
  wire [22:0]  pl_p = pl_addr * 14'd18;

  wire a_go = a_ce_q & a_cs_q;
  wire b_go = b_ce_q & b_cs_q;
  assign a_wr = fifo_m ? pop : (a_go & a_we_q & ~rom_mode);
  assign a_rd = ~fifo_m & ~wide & a_go & ~a_we_q;
  assign b_wr = (mode == `EBU_MODE_TDP) & b_go & b_we_q & ~rom_mode;
  assign b_rd = fifo_m ? frd :
                (mode == `EBU_MODE_PDP) ? b_go :
                (mode == `EBU_MODE_TDP) ? (b_go & ~b_we_q) : 1'b0;
  assign pop = fifo_m & st_valid & write_port_select & full_chain_input
               & ~full_flag & ~fifo_reset & ~rom_mode;
  assign frd = fifo_m & fifo_rd_en & read_port_select & empty_chain_input
               & ~empty_flag & ~fifo_reset;
  assign ba = fn_base(fifo_m ? (wp_q & fn_dm(a_width, wide)) :
                      {1'b0, a_ad_q}, a_width, wide);
  assign bb = fn_base(fifo_m ? (rp_q & fn_dm(a_width, wide)) :
                      {1'b0, b_ad_q}, bc, wide);
  assign wda = fifo_m ? st_data : a_di_q;
  assign pl_base = pl_p[13:0];

  ebu_stage_fifo #(
    .W     (`EBU_DW),
    .DEPTH (`EBU_STAGE_DEPTH),
    .AW    (`EBU_STAGE_AW)
  ) u_stage (
    .clk       (clk),
    .reset_n   (reset_n),
    .clr       (fifo_reset),
    .in_valid  (fifo_wr_en & fifo_m),
    .in_ready  (fifo_wr_ready),
    .in_data   (fifo_write_word_in),
    .out_valid (st_valid),
    .out_ready (pop),
    .out_data  (st_data)
  );

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      a_ce_q <= 1'b0;
      a_cs_q <= 1'b0;
      a_we_q <= 1'b0;
      a_be_q <= 2'h0;
      a_ad_q <= 13'h0;
      a_di_q <= 18'h0;
      b_ce_q <= 1'b0;
      b_cs_q <= 1'b0;
      b_we_q <= 1'b0;
      b_be_q <= 2'h0;
      b_ad_q <= 13'h0;
      b_di_q <= 18'h0;
    end else begin
      a_ce_q <= a_clk_en;
      a_cs_q <= a_sel;
      a_we_q <= a_wr_en;
      a_be_q <= a_byte_lane_select;
      a_ad_q <= a_addr;
      a_di_q <= a_write_word_in;
      b_ce_q <= b_clk_en;
      b_cs_q <= b_sel;
      b_we_q <= b_wr_en;
      b_be_q <= b_byte_lane_select;
      b_ad_q <= b_addr;
      b_di_q <= b_write_word_in;
    end
  end

  initial begin
    for (n = 0; n < `EBU_BITS; n = n + 1)
      mem[n] = 1'b0;
  end

  always @(posedge clk) begin
    for (j = 0; j < `EBU_DW; j = j + 1) begin
      if (a_wr && j < wa && (wa != 5'h12 || fifo_m || a_be_q[j / `EBU_LANE1_LSB]))
        mem[ba + j[13:0]] <= wda[j];
      if (b_wr && j < wb && (wb != 5'h12 || b_be_q[j / `EBU_LANE1_LSB]))
        mem[bb + j[13:0]] <= b_di_q[j];
      if (pl_en)
        mem[pl_base + j[13:0]] <= pl_word[j];
    end
  end

  always @* begin
    rd_a = 18'h0;
    rd_b = 18'h0;
    for (i = 0; i < `EBU_DW; i = i + 1) begin
      if (i < wa)
        rd_a[i] = mem[ba + i[13:0]];
      if (i < wb)
        rd_b[i] = mem[bb + i[13:0]];
    end
  end

  always @* begin
    la_d = la_q;
    lb_d = lb_q;
    if (port_a_latch_clear)
      la_d = 18'h0;
    else if (a_rd)
      la_d = rd_a;
    else if (a_wr && !fifo_m) begin
      case (a_wr_mode)
        `EBU_WM_THROUGH: la_d = wda & fn_mask(wa);
        `EBU_WM_RBW:     la_d = rd_a;
        default:         la_d = la_q;
      endcase
    end
    if (port_b_latch_clear)
      lb_d = 18'h0;
    else if (b_rd)
      lb_d = rd_b;
    else if (b_wr) begin
      case (b_wr_mode)
        `EBU_WM_THROUGH: lb_d = b_di_q & fn_mask(wb);
        `EBU_WM_RBW:     lb_d = rd_b;
        default:         lb_d = lb_q;
      endcase
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      la_q        <= 18'h0;
      lb_q        <= 18'h0;
      a_read_word <= 18'h0;
      b_read_word <= 18'h0;
    end else begin
      la_q <= la_d;
      lb_q <= lb_d;
      if (port_a_latch_clear)
        a_read_word <= 18'h0;
      else if (!a_out_reg)
        a_read_word <= la_d;
      else if (a_output_register_enable)
        a_read_word <= la_q;
      if (port_b_latch_clear)
        b_read_word <= 18'h0;
      else if (!b_out_reg)
        b_read_word <= lb_d;
      else if (fifo_m ? output_read_enable : b_output_register_enable)
        b_read_word <= lb_q;
    end
  end

  always @* begin
    wp_d = wp_q;
    rp_d = rp_q;
    if (fifo_reset) begin
      wp_d = 14'h0;
      rp_d = 14'h0;
    end else begin
      if (pop)
        wp_d = (wp_q + 14'h1) & wrap;
      if (read_pointer_rewind)
        rp_d = 14'h0;
      else if (frd)
        rp_d = (rp_q + 14'h1) & wrap;
    end
    cnt_d = (wp_d - rp_d) & wrap;
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_q              <= 14'h0;
      rp_q              <= 14'h0;
      full_flag         <= 1'b0;
      nearly_full_flag  <= 1'b0;
      nearly_empty_flag <= 1'b1;
      empty_flag        <= 1'b1;
    end else begin
      wp_q              <= wp_d;
      rp_q              <= rp_d;
      full_flag         <= (cnt_d >= full_level);
      nearly_full_flag  <= (cnt_d >= afull_level);
      nearly_empty_flag <= (cnt_d <= aempty_level);
      empty_flag        <= (cnt_d == 14'h0);
    end
  end
endmodule // ebu_block_memory

/* File: pkg/ebu_map.vh */
/*
  ebu_map.vh: codes, sizes and field positions of the block memory unit.
  assumes it is included by bare name from the design files.
*/
// Overview of operation
// - 9216-bit array, registered inputs and outputs
// - modes: single, true dual, pseudo dual, fifo
// - widths 1,2,4,9; 18 in pseudo/fifo
// - each port may use its own width outside fifo mode; in fifo both sides use the port a width
// - bits packed lsb-first, word after word
// - array may be preloaded at configuration
// - preloaded with writes disabled acts as rom
// - address and write data registered before array
// - output register only when configured
// - fifo gives nearly full, full, nearly empty, empty
// - rewind input resets only the read pointer
// - dual port: full signal set per port
// - fifo read and write sides own selects
// - chain inputs act as write/read selects
// - normal mode: output changes on reads only
// - write-through: written data shows at output
// - read-before-write: old contents show at output
// - fifo flags registered on the port clock
// - fifo reset clears pointers and flags
// - latch clear per port, global clears both
`ifndef EBU_MAP_VH
`define EBU_MAP_VH
`define EBU_BITS        9216
`define EBU_DW          18
`define EBU_LANE1_LSB   9
`define EBU_MODE_SP     2'h0
`define EBU_MODE_TDP    2'h1
`define EBU_MODE_PDP    2'h2
`define EBU_MODE_FIFO   2'h3
`define EBU_W1          3'h0
`define EBU_W2          3'h1
`define EBU_W4          3'h2
`define EBU_W9          3'h3
`define EBU_W18         3'h4
`define EBU_WM_NORMAL   2'h0
`define EBU_WM_THROUGH  2'h1
`define EBU_WM_RBW      2'h2
`define EBU_STAGE_DEPTH 8
`define EBU_STAGE_AW    3
`endif

/* File: verilog/ebu_stage_fifo.v */
/*
  ebu_stage_fifo: small valid/ready buffer in the fifo write path.
  assumes DEPTH equals 2**AW and one clock for both sides.
*/
`timescale 1ns/1ps
module ebu_stage_fifo #(
  parameter W     = 18,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire         clk,       // clock
  input  wire         reset_n,   // async reset
  input  wire         clr,       // sync flush
  input  wire         in_valid,  // source has word
  output wire         in_ready,  // room left
  input  wire [W-1:0] in_data,   // word in
  output wire         out_valid, // word held
  input  wire         out_ready, // sink takes word
  output wire [W-1:0] out_data   // oldest word
);
  localparam [AW:0] FULL_C = DEPTH[AW:0];
  reg  [W-1:0]  buf_q [0:DEPTH-1];
  reg  [AW-1:0] wp_q;
  reg  [AW-1:0] rp_q;
  reg  [AW:0]   cnt_q;
  reg           rdy_q;
  wire          push;
  wire          pop;
  wire [AW:0]   cnt_d;

  assign push      = in_valid & rdy_q;
  assign pop       = out_valid & out_ready;
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = buf_q[rp_q];
  assign in_ready  = rdy_q;
  assign cnt_d     = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  always @(posedge clk) begin
    if (push)
      buf_q[wp_q] <= in_data;
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_q  <= {AW{1'b0}};
      rp_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      rdy_q <= 1'b0;
    end else if (clr) begin
      wp_q  <= {AW{1'b0}};
      rp_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      rdy_q <= 1'b1;
    end else begin
      if (push)
        wp_q <= wp_q + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
        rp_q <= rp_q + {{(AW-1){1'b0}}, 1'b1};
      cnt_q <= cnt_d;
      // stalls the source when the buffer fills
      rdy_q <= (cnt_d != FULL_C);
    end
  end
endmodule // ebu_stage_fifo

/* File: tb/ebu_block_memory_props.sv */
/* ebu_block_memory_props: port-level checks of the block memory.
   assumes a bind onto ebu_block_memory and one clock domain. */
`timescale 1ns/1ps
`include "ebu_map.vh"
module ebu_block_memory_props (
  input logic        clk,                 // clock
  input logic        reset_n,             // async reset
  input logic [1:0]  mode,                // memory mode
  input logic        b_out_reg,           // port b out reg
  input logic        a_clk_en,            // port a enable
  input logic        b_clk_en,            // port b enable
  input logic        port_a_latch_clear,  // port a clear
  input logic        port_b_latch_clear,  // port b clear
  input logic [17:0] a_read_word,         // port a out
  input logic [17:0] b_read_word,         // port b out
  input logic        fifo_reset,          // fifo reset
  input logic        read_pointer_rewind, // rewind
  input logic        fifo_wr_en,          // fifo write
  input logic        fifo_rd_en,          // fifo read
  input logic        full_flag,           // full
  input logic        nearly_full_flag,    // nearly full
  input logic        nearly_empty_flag,   // nearly empty
  input logic        empty_flag           // empty
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire fm = (mode == `EBU_MODE_FIFO);
  a_reset_flags: assert property ($rose(reset_n) |-> empty_flag && nearly_empty_flag &&
    !full_flag && !nearly_full_flag) else $error("flags wrong after reset");
  a_flags_apart: assert property (!(full_flag && empty_flag))
    else $error("full and empty together");
  a_full_nearly: assert property (full_flag |-> nearly_full_flag)
    else $error("full without nearly full");
  a_empty_nearly: assert property (empty_flag |-> nearly_empty_flag)
    else $error("empty without nearly empty");
  a_reset_empties: assert property (fm && fifo_reset && !fifo_wr_en |-> ##[1:2] empty_flag)
    else $error("fifo reset left data");
  a_full_holds: assert property (full_flag && !fifo_rd_en && !fifo_reset &&
    !$past(fifo_rd_en) && !$past(fifo_reset) |=> full_flag) else $error("full dropped");
  a_clear_a: assert property (port_a_latch_clear && !a_clk_en && !$past(a_clk_en)
    |=> a_read_word == 18'h0) else $error("port a not cleared");
  a_clear_b_only: assert property (port_a_latch_clear && !port_b_latch_clear && !fm &&
    !b_out_reg && !b_clk_en && !$past(b_clk_en) && !$past(b_clk_en, 2) |=> $stable(b_read_word))
    else $error("port b hit by port a clear");
  a_rewind_data: assert property (fm && read_pointer_rewind && !empty_flag && !fifo_reset
    |-> ##[1:2] !empty_flag) else $error("rewind lost data");
endmodule // ebu_block_memory_props

/* File: tb/ebu_fifo_reader.sv */
/* ebu_fifo_reader: user logic pulling words from the fifo read side.
   assumes the memory clock and flags registered on it. */
`timescale 1ns/1ps
module ebu_fifo_reader (
  input  logic clk,        // clock
  input  logic reset_n,    // async reset
  input  logic go,         // reads allowed
  input  logic empty_flag, // fifo empty
  output logic fifo_rd_en, // read request
  output logic got_valid   // data on read word
);
  logic [1:0] gap_q;
  logic       rd_q;
  logic       take_q;
  assign fifo_rd_en = rd_q;
  assign got_valid = take_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_q <= 1'b0;
      take_q <= 1'b0;
      gap_q <= 2'h0;
    end else begin
      take_q <= rd_q && !empty_flag;
      rd_q <= 1'b0;
      if (gap_q != 2'h0) gap_q <= gap_q - 2'h1;
      else if (go && !empty_flag) begin
        rd_q <= 1'b1;
        gap_q <= 2'h3;
      end
    end
  end
endmodule // ebu_fifo_reader

/* File: tb/embedded_block_ram_unit_tb_top.sv */
/* embedded_block_ram_unit_tb_top: self-checking bench of the block memory.
   assumes the design, reader and checker files are compiled first. */
`timescale 1ns/1ps
`include "ebu_map.vh"
module embedded_block_ram_unit_tb_top;
  logic clk = 0, reset_n = 0, rom_mode = 0, a_out_reg = 0, b_out_reg = 0, pl_en = 0, go = 0;
  logic a_clk_en = 0, a_sel = 0, a_wr_en = 0, port_a_latch_clear = 0, b_clk_en = 0, b_sel = 0;
  logic b_wr_en = 0, port_b_latch_clear = 0, fifo_reset = 0, read_pointer_rewind = 0;
  logic fifo_wr_en = 0, write_port_select = 1, full_chain_input = 1, read_port_select = 1;
  logic empty_chain_input = 1, output_read_enable = 1;
  logic a_output_register_enable = 1, b_output_register_enable = 1;
  logic [1:0] mode = 0, a_wr_mode = 0, b_wr_mode = 0, a_byte_lane_select = 0;
  logic [1:0] b_byte_lane_select = 0;
  logic [2:0] a_width = 3, b_width = 3, wa, wb;
  logic [8:0] pl_addr = 0;
  logic [12:0] a_addr = 0, b_addr = 0;
  logic [13:0] full_level = 14'h6, afull_level = 14'h4, aempty_level = 14'h1;
  logic [17:0] pl_word = 0, a_write_word_in = 0, b_write_word_in = 0, fifo_write_word_in = 0;
  logic [17:0] d, o, rx, q[$], hist[$];
  logic [9215:0] img = '0;
  wire [17:0] a_read_word, b_read_word;
  wire fifo_wr_ready, fifo_rd_en, got_valid, full_flag, nearly_full_flag;
  wire nearly_empty_flag, empty_flag;
  int err_count = 0, samples_checked = 0, seed = 11, cyc_n = 0, i, k, ad, ok;
  always #2.5 clk = ~clk;
  ebu_block_memory dut (.clk, .reset_n, .mode, .rom_mode, .a_width, .b_width, .a_wr_mode,
    .b_wr_mode, .a_out_reg, .b_out_reg, .pl_en, .pl_addr, .pl_word, .a_clk_en, .a_sel,
    .a_wr_en, .a_byte_lane_select, .a_addr, .a_write_word_in, .a_output_register_enable,
    .port_a_latch_clear, .a_read_word, .b_clk_en, .b_sel, .b_wr_en, .b_byte_lane_select,
    .b_addr, .b_write_word_in, .b_output_register_enable, .port_b_latch_clear, .b_read_word,
    .fifo_reset, .read_pointer_rewind, .fifo_wr_en, .fifo_write_word_in, .fifo_wr_ready,
    .write_port_select, .full_chain_input, .fifo_rd_en, .read_port_select,
    .empty_chain_input, .output_read_enable, .full_level, .afull_level, .aempty_level,
    .full_flag, .nearly_full_flag, .nearly_empty_flag, .empty_flag);
  ebu_fifo_reader u_rd (.clk, .reset_n, .go, .empty_flag, .fifo_rd_en, .got_valid);
  function automatic int wbits(input logic [2:0] c);
    return c == 0 ? 1 : c == 1 ? 2 : c == 2 ? 4 : c == 3 ? 9 : 18;
  endfunction
  function automatic logic [17:0] ex(input logic [2:0] c, input int a);
    ex = '0;
    for (int j = 0; j < wbits(c); j++) ex[j] = img[a * wbits(c) + j];
  endfunction
  task automatic put(input logic [2:0] c, input int a, input logic [17:0] v, input logic [1:0] l);
    for (int j = 0; j < wbits(c); j++) if (c != 4 || l[j / 9]) img[a * wbits(c) + j] = v[j];
  endtask
  task automatic chk(input logic [17:0] g, e, input logic [2:0] c);
    logic [17:0] m;
    m = 18'h3ffff >> (18 - wbits(c));
    samples_checked++;
    if ((g & m) !== e) begin
      err_count++;
      $display("ERROR t=%0t got %h exp %h", $time, g & m, e);
    end
  endtask
  task automatic chk_f(input logic g, e);
    chk({17'h0, g}, {17'h0, e}, 0);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic pa(input logic s, we, input int a, input logic [17:0] v);
    a_clk_en <= 1;
    a_sel <= s;
    a_wr_en <= we;
    a_addr <= a[12:0];
    a_write_word_in <= v;
    @(posedge clk);
    a_clk_en <= 0;
    cyc(4);
  endtask
  task automatic pb(input logic we, input int a, input logic [17:0] v);
    b_clk_en <= 1;
    b_sel <= 1;
    b_wr_en <= we;
    b_addr <= a[12:0];
    b_write_word_in <= v;
    @(posedge clk);
    b_clk_en <= 0;
    cyc(4);
  endtask
  task automatic fw(input logic [17:0] v);
    fifo_wr_en <= 1;
    fifo_write_word_in <= v;
    ok = 0;
    for (int n = 0; n < 6 && !ok; n++) begin
      @(posedge clk);
      ok = fifo_wr_ready;
    end
    if (ok) q.push_back(v);
    if (ok) hist.push_back(v);
  endtask
  task automatic drain;
    go <= 1;
    for (int n = 0; n < 300 && q.size() > 0; n++) @(posedge clk);
    go <= 0;
    cyc(6);
    chk_f(q.size() == 0, 1);
    chk_f(empty_flag, 1);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) if (got_valid) begin
    rx = q.size() ? q.pop_front() : ~b_read_word;
    chk(b_read_word, rx, 4);
  end
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      err_count++;
      report_and_stop;
    end
  end
  initial begin
    cyc(2);
    reset_n <= 1;
    cyc(2);
    mode <= `EBU_MODE_PDP;
    for (i = 0; i < 40; i++) begin
      wa = {$random(seed)} % 5;
      wb = {$random(seed)} % 5;
      ad = {$random(seed)} % (8192 / wbits(wa));
      d = $random(seed);
      k = $random(seed);
      a_width <= wa;
      b_width <= wb;
      b_out_reg <= k[3];
      a_byte_lane_select <= k[2:1];
      @(posedge clk);
      pa(k[0], 1, ad, d);
      if (k[0]) put(wa, ad, d, k[2:1]);
      ad = ad * wbits(wa) / wbits(wb);
      pb(1, ad, ~d);
      pb(0, ad, 0);
      chk(b_read_word, ex(wb, ad), wb);
    end
    mode <= `EBU_MODE_TDP;
    a_width <= 3;
    b_width <= 0;
    b_out_reg <= 0;
    pa(1, 0, 7, 0);
    for (i = 0; i < 3; i++) begin
      a_wr_mode <= i[1:0];
      o = ex(3, 7);
      d = $random(seed);
      pa(1, 1, 7, d);
      put(3, 7, d, 3);
      chk(a_read_word, i == 1 ? ex(3, 7) : o, 3);
    end
    b_wr_mode <= 2'h1;
    o = ~ex(0, 64);
    pb(1, 64, o);
    put(0, 64, o, 3);
    chk(b_read_word, ex(0, 64), 0);
    for (k = 63; k < 72; k++) begin
      pb(0, k, 0);
      chk(b_read_word, ex(0, k), 0);
    end
    mode <= `EBU_MODE_SP;
    rom_mode <= 1;
    pl_en <= 1;
    pl_addr <= 9'h14;
    pl_word <= d;
    @(posedge clk);
    pl_en <= 0;
    put(4, 20, d, 3);
    for (k = 40; k < 42; k++) begin
      pa(1, 1, k, ~d);
      pa(1, 0, k, 0);
      chk(a_read_word, ex(3, k), 3);
    end
    rom_mode <= 0;
    a_out_reg <= 1;
    pa(1, 0, 40, 0);
    chk(a_read_word, ex(3, 40), 3);
    a_output_register_enable <= 0;
    pa(1, 0, 41, 0);
    chk(a_read_word, ex(3, 40), 3);
    a_output_register_enable <= 1;
    cyc(3);
    chk(a_read_word, ex(3, 41), 3);
    port_a_latch_clear <= 1;
    @(posedge clk);
    port_a_latch_clear <= 0;
    cyc(3);
    chk(a_read_word, 0, 4);
    chk(b_read_word, ex(0, 71), 0);
    a_out_reg <= 0;
    mode <= `EBU_MODE_FIFO;
    a_width <= 4;
    fifo_reset <= 1;
    @(posedge clk);
    fifo_reset <= 0;
    cyc(3);
    chk_f(empty_flag, 1);
    full_chain_input <= 0;
    for (k = 0; k < 3; k++) fw($random(seed));
    fifo_wr_en <= 0;
    cyc(6);
    chk_f(empty_flag, 1);
    full_chain_input <= 1;
    cyc(6);
    chk_f(empty_flag, 0);
    read_pointer_rewind <= 1;
    @(posedge clk);
    read_pointer_rewind <= 0;
    drain;
    read_pointer_rewind <= 1;
    @(posedge clk);
    read_pointer_rewind <= 0;
    q = hist;
    drain;
    fifo_reset <= 1;
    @(posedge clk);
    fifo_reset <= 0;
    hist.delete();
    ok = 1;
    for (k = 0; k < 40 && ok; k++) fw($random(seed));
    fifo_wr_en <= 0;
    cyc(4);
    chk_f(full_flag, 1);
    chk_f(nearly_full_flag, 1);
    chk_f(fifo_wr_ready, 0);
    drain;
    chk_f(nearly_empty_flag, 1);
    report_and_stop;
  end
endmodule // embedded_block_ram_unit_tb_top
bind ebu_block_memory ebu_block_memory_props u_props (.clk, .reset_n, .mode, .b_out_reg,
  .a_clk_en, .b_clk_en, .port_a_latch_clear, .port_b_latch_clear, .a_read_word, .b_read_word,
  .fifo_reset, .read_pointer_rewind, .fifo_wr_en, .fifo_rd_en, .full_flag, .nearly_full_flag,
  .nearly_empty_flag, .empty_flag);
